//--- sfc_regs.svh
// Timing constants for the static memory host controller.
// Assumes a 10 MHz reference clock; all times in picoseconds.
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH
`define SFC_CLK_PERIOD_PS        100000
// Fast grade figures (ps)
`define SFC_ADDR_ACCESS_PS       45000
// Slow grade access, used so one build serves both grades
`define SFC_SLOW_ACCESS_PS       55000
`define SFC_STROBE_ACCESS_PS     22000
`define SFC_OUT_HOLD_PS          10000
`define SFC_FLOAT_PS             18000
`define SFC_WR_FLOAT_PS          20000
`define SFC_ADDR_SETUP_WEND_PS   40000
`define SFC_DATA_SETUP_WEND_PS   25000
`define SFC_BYTE_WEND_PS         40000
// Cycle counts, least times rounded up
`define SFC_CEIL(t) (((t) + `SFC_CLK_PERIOD_PS - 1) / `SFC_CLK_PERIOD_PS)
`define SFC_READ_CYC   `SFC_CEIL(`SFC_SLOW_ACCESS_PS)
`define SFC_FLOAT_CYC  `SFC_CEIL(`SFC_FLOAT_PS)
`define SFC_WRITE_CYC  `SFC_CEIL(`SFC_WR_FLOAT_PS + `SFC_DATA_SETUP_WEND_PS)
`endif

//--- sfc_pkg.sv
// Types for the static memory host controller.
// Assumes nothing beyond the timing header.
package sfc_pkg;
  typedef enum logic [4:0] {
    SFC_IDLE  = 5'b00001,
    SFC_READ  = 5'b00010,
    SFC_WSET  = 5'b00100,
    SFC_WRITE = 5'b01000,
    SFC_TURN  = 5'b10000
  } sfc_state_type;
endpackage

//--- sfc_ctrl.sv
// Host controller for an asynchronous 16-bit static memory with error flag.
// Assumes memory pins are resolved by the surroundings from the enables.
`include "sfc_regs.svh"
module sfc_ctrl
  import sfc_pkg::*;
#(
  parameter int ADDR_W    = 20,
  parameter int READ_CYC  = `SFC_READ_CYC,
  parameter int WRITE_CYC = `SFC_WRITE_CYC,
  parameter int FLOAT_CYC = `SFC_FLOAT_CYC
)(
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  input  wire logic              CLK_EN,
  input  wire logic              REQ_VALID,
  input  wire logic              REQ_WRITE,
  input  wire logic [ADDR_W-1:0] REQ_ADDR,
  input  wire logic [15:0]       REQ_WDATA,
  input  wire logic [1:0]        REQ_BYTE_EN,
  output logic                   REQ_READY,
  output logic                   RSP_VALID,
  output logic [15:0]            RSP_RDATA,
  output logic                   RSP_ERR,
  output logic [ADDR_W-1:0]      MEM_ADDR,
  output logic                   MEM_CHIP_SELECT_LOW,
  output logic                   MEM_CHIP_SELECT_HIGH,
  output logic                   MEM_WRITE_N,
  output logic                   MEM_OUTPUT_N,
  output logic                   MEM_UPPER_BYTE_STROBE_N,
  output logic                   MEM_LOWER_BYTE_STROBE_N,
  input  wire logic [15:0]       MEM_DATA_IN,
  output logic [15:0]            MEM_DATA_OUT,
  output logic [15:0]            MEM_DATA_OE,
  input  wire logic              MEM_ERR_IN
);
  localparam int CNT_W = 8;

  sfc_state_type     state_r, state_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [15:0]       wdata_r, wdata_nxt;
  logic [15:0]       oe_r, oe_nxt;
  logic [1:0]        be_r, be_nxt;
  logic              sel_r, sel_nxt;
  logic              we_n_r, we_n_nxt;
  logic              oe_n_r, oe_n_nxt;
  logic              ready_r, ready_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic [15:0]       rdata_r, rdata_nxt;
  logic              err_r, err_nxt;
  logic [15:0]       din_s1_r, din_s2_r;
  logic              err_s1_r, err_s2_r;
  logic              sel_n_r, sel_n_nxt;
  logic [1:0]        be_n_r, be_n_nxt;
  logic [CNT_W-1:0]  wlow_r, wlow_nxt;
  logic [CNT_W-1:0]  rlow_r, rlow_nxt;

  function automatic logic [15:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [CNT_W-1:0] cnt_of(input int n);
    cnt_of = CNT_W'(n);
  endfunction

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      din_s1_r <= 16'h0000;
      din_s2_r <= 16'h0000;
      err_s1_r <= 1'b0;
      err_s2_r <= 1'b0;
    end
    else if (CLK_EN)
    begin
      din_s1_r <= MEM_DATA_IN;
      din_s2_r <= din_s1_r;
      err_s1_r <= MEM_ERR_IN;
      err_s2_r <= err_s1_r;
    end
  end

  always_comb
  begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    addr_nxt   = addr_r;
    wdata_nxt  = wdata_r;
    oe_nxt     = oe_r;
    be_nxt     = be_r;
    sel_nxt    = sel_r;
    we_n_nxt   = we_n_r;
    oe_n_nxt   = oe_n_r;
    ready_nxt  = ready_r;
    rvalid_nxt = 1'b0;
    rdata_nxt  = rdata_r;
    err_nxt    = err_r;
    unique case (state_r)
      SFC_IDLE:
      begin
        if (!ready_r)
          ready_nxt = 1'b1;
        if (REQ_VALID && ready_r && (REQ_BYTE_EN != 2'b00))
        begin
          ready_nxt = 1'b0;
          addr_nxt  = REQ_ADDR;
          be_nxt    = REQ_BYTE_EN;
          wdata_nxt = REQ_WDATA;
          sel_nxt   = 1'b1;
          if (REQ_WRITE)
          begin
            state_nxt = SFC_WSET;
            oe_nxt    = lane_mask(REQ_BYTE_EN);
          end
          else
          begin
            // Extra two cycles cover the input synchroniser
            state_nxt = SFC_READ;
            oe_n_nxt  = 1'b0;
            cnt_nxt   = cnt_of(READ_CYC + 2);
          end
        end
      end
      SFC_READ:
      begin
        if (cnt_r == cnt_of(0))
        begin
          rdata_nxt  = din_s2_r & lane_mask(be_r);
          err_nxt    = err_s2_r;
          rvalid_nxt = 1'b1;
          oe_n_nxt   = 1'b1;
          sel_nxt    = 1'b0;
          be_nxt     = 2'b00;
          state_nxt  = SFC_TURN;
          cnt_nxt    = cnt_of(FLOAT_CYC);
        end
        else
          cnt_nxt = cnt_r - cnt_of(1);
      end
      SFC_WSET:
      begin
        we_n_nxt  = 1'b0;
        state_nxt = SFC_WRITE;
        cnt_nxt   = cnt_of(WRITE_CYC);
      end
      SFC_WRITE:
      begin
        if (cnt_r == cnt_of(1))
        begin
          we_n_nxt  = 1'b1;
          state_nxt = SFC_TURN;
          cnt_nxt   = cnt_of(1);
        end
        else
          cnt_nxt = cnt_r - cnt_of(1);
      end
      SFC_TURN:
      begin
        oe_nxt  = 16'h0000;
        sel_nxt = 1'b0;
        be_nxt  = 2'b00;
        if (cnt_r <= cnt_of(1))
        begin
          state_nxt = SFC_IDLE;
          ready_nxt = 1'b1;
          cnt_nxt   = cnt_of(0);
        end
        else
          cnt_nxt = cnt_r - cnt_of(1);
      end
    endcase
    // Active-low pins get their own flops
    sel_n_nxt = ~sel_nxt;
    be_n_nxt  = ~be_nxt;
  end

  // Strobe-low lengths, watched by the timing checks
  always_comb
  begin
    wlow_nxt = we_n_r ? cnt_of(0) : wlow_r + cnt_of(1);
    rlow_nxt = oe_n_r ? cnt_of(0) : rlow_r + cnt_of(1);
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      wlow_r <= 8'h00;
      rlow_r <= 8'h00;
    end
    else if (CLK_EN)
    begin
      wlow_r <= wlow_nxt;
      rlow_r <= rlow_nxt;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      state_r  <= SFC_IDLE;
      cnt_r    <= 8'h00;
      addr_r   <= '0;
      wdata_r  <= 16'h0000;
      oe_r     <= 16'h0000;
      be_r     <= 2'b00;
      sel_r    <= 1'b0;
      sel_n_r  <= 1'b1;
      be_n_r   <= 2'b11;
      we_n_r   <= 1'b1;
      oe_n_r   <= 1'b1;
      ready_r  <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r  <= 16'h0000;
      err_r    <= 1'b0;
    end
    else if (CLK_EN)
    begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      addr_r   <= addr_nxt;
      wdata_r  <= wdata_nxt;
      oe_r     <= oe_nxt;
      be_r     <= be_nxt;
      sel_r    <= sel_nxt;
      sel_n_r  <= sel_n_nxt;
      be_n_r   <= be_n_nxt;
      we_n_r   <= we_n_nxt;
      oe_n_r   <= oe_n_nxt;
      ready_r  <= ready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      err_r    <= err_nxt;
    end
  end

  assign REQ_READY               = ready_r;
  assign RSP_VALID               = rvalid_r;
  assign RSP_RDATA               = rdata_r;
  assign RSP_ERR                 = err_r;
  assign MEM_ADDR                = addr_r;
  assign MEM_CHIP_SELECT_LOW     = sel_n_r;
  assign MEM_CHIP_SELECT_HIGH    = sel_r;
  assign MEM_WRITE_N             = we_n_r;
  assign MEM_OUTPUT_N            = oe_n_r;
  assign MEM_UPPER_BYTE_STROBE_N = be_n_r[1];
  assign MEM_LOWER_BYTE_STROBE_N = be_n_r[0];
  assign MEM_DATA_OUT            = wdata_r;
  assign MEM_DATA_OE             = oe_r;

  no_read_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !oe_n_r |-> we_n_r) else $error("write strobe low during read");
  wr_needs_sel_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !we_n_r |-> sel_r && be_r != 2'b00) else $error("write w/o select");
  no_drive_read_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !oe_n_r |-> oe_r == 16'h0000) else $error("bus clash in read");
  sequence wr_end_s;
    $rose(we_n_r);
  endsequence
  sequence rd_end_s;
    $rose(rvalid_r);
  endsequence
  wr_width_a: assert property (@(posedge REF_CLK) disable iff (RST)
    wr_end_s |-> int'(wlow_r) * `SFC_CLK_PERIOD_PS >=
    `SFC_WR_FLOAT_PS + `SFC_DATA_SETUP_WEND_PS) else $error("write pulse short");
  byte_len_a: assert property (@(posedge REF_CLK) disable iff (RST)
    wr_end_s |-> int'(wlow_r) * `SFC_CLK_PERIOD_PS >= `SFC_BYTE_WEND_PS)
    else $error("byte strobe short");
  rd_wait_a: assert property (@(posedge REF_CLK) disable iff (RST)
    rd_end_s |-> int'(rlow_r) * `SFC_CLK_PERIOD_PS >= `SFC_SLOW_ACCESS_PS)
    else $error("read sampled early");
  frz_state_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !CLK_EN |=> $stable(state_r)) else $error("state moved while frozen");
  addr_stable_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !we_n_r |=> $stable(addr_r) || we_n_r) else $error("addr moved");
  data_hold_a: assert property (@(posedge REF_CLK) disable iff (RST)
    $rose(we_n_r) |-> oe_r != 16'h0000) else $error("data early drop");
  lane_oe_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !we_n_r |-> oe_r == lane_mask(be_r)) else $error("lane mismatch");
  sel_pair_a: assert property (@(posedge REF_CLK) disable iff (RST)
    MEM_CHIP_SELECT_LOW != MEM_CHIP_SELECT_HIGH) else $error("sel");
endmodule

//--- sfc_mem_model.sv
// Behavioural 16-bit static memory with error flag, fast grade legal timing.
// Assumes the bench resolves the shared data lines from all enables.
module sfc_mem_model #(
  parameter int ACC    = 45,
  parameter int OE_ACC = 22
)(
  input  wire logic [19:0] addr,
  input  wire logic        cs_low,
  input  wire logic        cs_high,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        ub_n,
  input  wire logic        lb_n,
  input  wire logic [15:0] din,
  input  wire logic        inject,
  output logic      [15:0] q,
  output logic      [15:0] q_en,
  output logic             err,
  output int               viol
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [logic [19:0]];
  logic        sel;
  logic        rd;
  logic        wr;
  logic [15:0] lane;
  logic [15:0] tgt;
  realtime     t_a = 0;
  realtime     t_d = 0;
  realtime     t_l = 0;
  realtime     t_s = 0;
  initial q = 16'h0;
  initial q_en = 16'h0;
  initial viol = 0;
  function automatic logic [15:0] rdm(logic [19:0] a);
    return mem.exists(a) ? mem[a] : 16'h0;
  endfunction
  assign sel = !cs_low && cs_high;
  assign lane = {{8{!ub_n}}, {8{!lb_n}}};
  assign rd = sel && we_n && !oe_n;
  assign wr = sel && !we_n && (lane != 16'h0);
  assign tgt = rd ? lane : 16'h0;
  assign err = inject;
  always @(posedge sel) t_s = $realtime;
  always @(lane) t_l = $realtime;
  always @(din & lane) t_d = $realtime;
  always @(addr)
  begin
    t_a = $realtime;
    q <= #10 ~q;
    #1 if (sel && t_s < t_a) viol++;
  end
  always @(addr, sel, lane) q <= #ACC rdm(addr);
  always @(negedge oe_n) q <= #OE_ACC rdm(addr);
  always @(tgt)
  begin
    q_en <= #5 q_en | tgt;
    q_en <= #18 tgt;
  end
  always @(negedge wr)
  begin
    if ($realtime > 0)
    begin
      if ($realtime - t_a < 40.0 || $realtime - t_l < 40.0) viol++;
      if ($realtime - t_d < 25.0) viol++;
      mem[addr] = (rdm(addr) & ~lane) | (din & lane);
    end
  end
endmodule

//--- sfc_ctrl_test.sv
// Bench for the static memory host controller against a memory model.
// Assumes the controller and the memory model are compiled first.
module sfc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK = 0, RST = 1, CLK_EN = 1, REQ_VALID = 0, REQ_WRITE = 0;
  logic [19:0] REQ_ADDR = 20'h0, MEM_ADDR;
  logic [15:0] REQ_WDATA = 16'h0, RSP_RDATA, MEM_DATA_IN, MEM_DATA_OUT;
  logic [15:0] MEM_DATA_OE, q, q_en, pat = 16'h5555;
  logic [1:0] REQ_BYTE_EN = 2'h0;
  logic REQ_READY, RSP_VALID, RSP_ERR, MEM_CHIP_SELECT_LOW, MEM_WRITE_N;
  logic MEM_CHIP_SELECT_HIGH, MEM_OUTPUT_N, MEM_UPPER_BYTE_STROBE_N;
  logic MEM_LOWER_BYTE_STROBE_N, MEM_ERR_IN, err, inject = 0;
  int viol, n_errors = 0, samples_checked = 0;
  sfc_ctrl dut_u (.REF_CLK(REF_CLK), .RST(RST), .CLK_EN(CLK_EN),
    .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR),
    .REQ_WDATA(REQ_WDATA), .REQ_BYTE_EN(REQ_BYTE_EN),
    .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
    .RSP_ERR(RSP_ERR), .MEM_ADDR(MEM_ADDR),
    .MEM_CHIP_SELECT_LOW(MEM_CHIP_SELECT_LOW),
    .MEM_CHIP_SELECT_HIGH(MEM_CHIP_SELECT_HIGH),
    .MEM_WRITE_N(MEM_WRITE_N), .MEM_OUTPUT_N(MEM_OUTPUT_N),
    .MEM_UPPER_BYTE_STROBE_N(MEM_UPPER_BYTE_STROBE_N),
    .MEM_LOWER_BYTE_STROBE_N(MEM_LOWER_BYTE_STROBE_N),
    .MEM_DATA_IN(MEM_DATA_IN), .MEM_DATA_OUT(MEM_DATA_OUT),
    .MEM_DATA_OE(MEM_DATA_OE), .MEM_ERR_IN(MEM_ERR_IN));
  sfc_mem_model mem_u (.addr(MEM_ADDR), .cs_low(MEM_CHIP_SELECT_LOW),
    .cs_high(MEM_CHIP_SELECT_HIGH), .we_n(MEM_WRITE_N),
    .oe_n(MEM_OUTPUT_N), .ub_n(MEM_UPPER_BYTE_STROBE_N),
    .lb_n(MEM_LOWER_BYTE_STROBE_N), .din(MEM_DATA_IN), .inject(inject),
    .q(q), .q_en(q_en), .err(err), .viol(viol));
  always #50 REF_CLK = ~REF_CLK;
  // Lines nobody drives toggle every cycle
  always @(posedge REF_CLK) pat <= ~pat;
  assign MEM_DATA_IN = (MEM_DATA_OE & MEM_DATA_OUT) |
    (~MEM_DATA_OE & q_en & q) | (~MEM_DATA_OE & ~q_en & pat);
  assign MEM_ERR_IN = (q_en != 16'h0) ? err : pat[0];
  task automatic chk(string nm, logic [19:0] e, logic [19:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  always @(negedge REF_CLK) if (!RST) chk("bus overlap", 20'h0, MEM_DATA_OE & q_en);
  task automatic step();
    @(posedge REF_CLK);
    #1;
  endtask
  task automatic req(logic w, logic [19:0] a, logic [15:0] d, logic [1:0] be);
    int n = 0;
    while (REQ_READY !== 1'b1 && n < 50)
    begin
      step();
      n++;
    end
    REQ_VALID = 1;
    REQ_WRITE = w;
    REQ_ADDR = a;
    REQ_WDATA = d;
    REQ_BYTE_EN = be;
    step();
    REQ_VALID = 0;
  endtask
  task automatic wr(logic [19:0] a, logic [15:0] d, logic [1:0] be);
    int n = 0;
    logic [15:0] m = {{8{be[1]}}, {8{be[0]}}};
    req(1'b1, a, d, be);
    while (MEM_WRITE_N !== 1'b0 && n < 20)
    begin
      step();
      n++;
    end
    chk("write pins", {3'h1, ~be}, {MEM_WRITE_N, MEM_CHIP_SELECT_LOW, MEM_CHIP_SELECT_HIGH, MEM_UPPER_BYTE_STROBE_N, MEM_LOWER_BYTE_STROBE_N});
    chk("write enable", m, MEM_DATA_OE);
    chk("write data", d & m, MEM_DATA_OUT & MEM_DATA_OE);
  endtask
  task automatic rd(logic [19:0] a, logic [1:0] be, logic [15:0] e, logic ee);
    int n = 0;
    req(1'b0, a, 16'h0, be);
    while (RSP_VALID !== 1'b1 && n < 20)
    begin
      chk("write strobe", 1'b1, MEM_WRITE_N);
      step();
      n++;
    end
    chk("read latency", 1'b1, n <= 10);
    chk("read data", e, RSP_RDATA);
    chk("read flag", ee, RSP_ERR);
    step();
    chk("answer pulse", 1'b0, RSP_VALID);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic t_lanes();
    wr(20'h12345, 16'ha5c3, 2'h3);
    rd(20'h12345, 2'h3, 16'ha5c3, 1'b0);
    wr(20'h12345, 16'h1e2f, 2'h1);
    rd(20'h12345, 2'h2, 16'ha500, 1'b0);
    wr(20'h12345, 16'h7788, 2'h2);
    rd(20'h12345, 2'h1, 16'h002f, 1'b0);
    rd(20'h12345, 2'h3, 16'h772f, 1'b0);
    $display("lane test done");
  endtask
  task automatic t_edges();
    wr(20'hfffff, 16'hffff, 2'h3);
    wr(20'h0, 16'h0001, 2'h3);
    rd(20'hfffff, 2'h3, 16'hffff, 1'b0);
    rd(20'h0, 2'h3, 16'h0001, 1'b0);
    $display("address test done");
  endtask
  task automatic t_refuse();
    req(1'b1, 20'h12345, 16'h0, 2'h0);
    repeat (3)
    begin
      step();
      chk("refused select", 1'b1, MEM_CHIP_SELECT_LOW);
    end
    rd(20'h12345, 2'h3, 16'h772f, 1'b0);
    $display("refuse test done");
  endtask
  task automatic t_err();
    inject = 1;
    rd(20'h0, 2'h3, 16'h0001, 1'b1);
    inject = 0;
    rd(20'h0, 2'h3, 16'h0001, 1'b0);
    $display("flag test done");
  endtask
  task automatic t_hold();
    int n = 0;
    req(1'b0, 20'h0, 16'h0, 2'h3);
    CLK_EN = 0;
    repeat (4)
    begin
      step();
      chk("frozen strobe", 1'b0, MEM_OUTPUT_N);
      chk("frozen answer", 1'b0, RSP_VALID);
    end
    CLK_EN = 1;
    while (RSP_VALID !== 1'b1 && n < 20)
    begin
      step();
      n++;
    end
    chk("frozen read", 16'h0001, RSP_RDATA);
    step();
    $display("hold test done");
  endtask
  initial
  begin
    #100000;
    n_errors++;
    finish_test();
  end
  initial
  begin
    repeat (8) @(posedge REF_CLK);
    #1 RST = 0;
    chk("idle pins", 6'h2f, {MEM_CHIP_SELECT_LOW, MEM_CHIP_SELECT_HIGH, MEM_WRITE_N, MEM_OUTPUT_N, MEM_UPPER_BYTE_STROBE_N, MEM_LOWER_BYTE_STROBE_N});
    t_lanes();
    t_edges();
    t_refuse();
    t_err();
    t_hold();
    chk("memory timing", 20'h0, viol);
    finish_test();
  end
endmodule
